// [verilog/ocs_pkg.sv]
/*
  constants for the oscillator switch control register block: register indices,
  field positions, reset values and source codes.
  assumes a 32-bit avalon-mm slave whose byte address is four times the index.
*/
package ocs_pkg;

  // ==========================================================================
  // register indices (byte address = index * 4)
  localparam logic [9:0] IDX_CLOCK_REQUEST = 10'h0ad;
  localparam logic [9:0] IDX_CLOCK_CURRENT = 10'h0ae;
  localparam logic [9:0] IDX_SWITCH_CONTROL = 10'h0af;
  localparam logic [9:0] IDX_FAST_OSC_TRIM = 10'h0b0;
  localparam logic [9:0] IDX_FAST_OSC_FREQUENCY = 10'h0b1;
  localparam logic [9:0] IDX_READY_FLAGS = 10'h0b2;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0b4;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0b5;

  // ==========================================================================
  // field positions
  localparam int SRC_LSB = 4;
  localparam int DIV_LSB = 0;
  localparam int CTL_HOLD_BIT = 7;
  localparam int CTL_PWR_BIT = 6;
  localparam int CTL_DONE_BIT = 4;
  localparam int CTL_NSR_BIT = 3;
  localparam int RDY_LSB = 3;
  localparam int IRQ_SWITCH_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_HELD_BIT = 2;

  // ==========================================================================
  // source codes; codes not listed here are reserved
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;
  localparam logic [2:0] SRC_FAST = 3'h6;
  localparam logic [2:0] SRC_SLOW = 3'h5;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_MEDIUM = 3'h3;

  // ready vector bit order: external, fast, medium, slow, secondary
  localparam int RDY_EXT = 4;
  localparam int RDY_FAST = 3;
  localparam int RDY_MED = 2;
  localparam int RDY_SLOW = 1;
  localparam int RDY_SEC = 0;

  // ==========================================================================
  // reset values and frequency code limit
  localparam logic [2:0] SRC_RST = 3'h6;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [3:0] FRQ_RST = 4'h0;
  localparam logic [3:0] FRQ_MAX = 4'h8;
  localparam logic [4:0] RDY_RST = 5'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT,
    SW_HOLD,
    SW_SWITCH
  } ocs_sw_state_t;

endpackage : ocs_pkg

// [verilog/ocs_top.sv]
/*
  oscillator switch control registers: request/current source and divider,
  switch hold, secondary power mode, fast oscillator trim and frequency,
  ready flags and a masked event interrupt, behind an avalon-mm slave.
  assumes straps are stable around reset release, ready and fail inputs are
  asynchronous, and the auto trim inputs come from logic on mclk_i.
*/
// Operation
// RULE1 - request source field bits 6:4 writable
// RULE2 - request divider field bits 3:0 writable
// RULE3 - reserved source write discards whole write
// RULE4 - switch disallowed: request fields fixed read-only
// RULE5 - current source/divider read-only, same encodings
// RULE6 - hold stalls switch once new source ready
// RULE7 - no hold: switch when new source ready
// RULE8 - power bit selects secondary high/low power
// RULE9 - done flag: request equals current
// RULE10 - new-ready flag: switch pending and source ready
// RULE11 - flag set, switch next cycle, flag cleared
// RULE12 - signed six-bit trim, zero is nominal
// RULE13 - frequency codes 0..8 valid, rest reserved
// RULE14 - ready flags bits 7..3 per oscillator
// RULE15 - ready flags cleared at reset
// RULE16 - clock fail forces fast source, raises flag
// RULE17 - auto trim drives trim, ignores writes
// RULE18 - releasing hold completes pending switch
`timescale 1ns/1ps
module ocs_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // configuration straps
  input wire logic switch_allow_config_i,
  input wire logic [2:0] reset_source_config_i,
  // oscillator status, asynchronous
  input wire logic [4:0] osc_ready_i,
  input wire logic clock_fail_i,
  // automatic trim, same clock
  input wire logic auto_trim_en_i,
  input wire logic [5:0] auto_trim_value_i,
  // clock control outputs and interrupt
  output logic [2:0] current_source_o,
  output logic [3:0] current_divider_o,
  output logic [5:0] trim_value_o,
  output logic [3:0] fast_freq_select_o,
  output logic secondary_power_select_o,
  output logic irq_o
);

  // ==========================================================================
  // state
  logic [2:0] req_src_r;
  logic [3:0] req_div_r;
  logic [2:0] cur_src_r;
  logic [3:0] cur_div_r;
  logic hold_r;
  logic pwr_r;
  logic nsr_r;
  logic [5:0] trim_r;
  logic [3:0] frq_r;
  logic [2:0] irq_sts_r;
  logic [2:0] irq_msk_r;
  logic allow_r;
  logic loaded_r;
  logic [4:0] rdy_s1_r;
  logic [4:0] rdy_s2_r;
  logic fail_s1_r;
  logic fail_s2_r;
  logic fail_q_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  ocs_pkg::ocs_sw_state_t st_r;

  // ==========================================================================
  // decode
  logic [9:0] idx;
  logic req_any;
  logic wr_commit;
  logic fail_rise;
  logic src_rsv;
  logic sel_rdy;
  logic done_w;
  logic [2:0] irq_set;
  logic [7:0] wbyte;

  assign idx = avs_address_i[11:2];
  assign req_any = avs_read_i | avs_write_i;
  // the write lands on the edge that the master sees waitrequest low
  assign wr_commit = avs_write_i & ~wait_r & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];
  assign fail_rise = fail_s2_r & ~fail_q_r;
  assign done_w = (req_src_r == cur_src_r) && (req_div_r == cur_div_r); // RULE9

  function automatic logic is_valid_src(input logic [2:0] s);
    is_valid_src = (s == ocs_pkg::SRC_EXTERNAL) || (s == ocs_pkg::SRC_FAST) ||
                   (s == ocs_pkg::SRC_SLOW) || (s == ocs_pkg::SRC_SECONDARY) ||
                   (s == ocs_pkg::SRC_MEDIUM);
  endfunction : is_valid_src

  function automatic logic src_ready(input logic [2:0] s, input logic [4:0] r);
    case (s)
      ocs_pkg::SRC_EXTERNAL: src_ready = r[ocs_pkg::RDY_EXT];
      ocs_pkg::SRC_FAST: src_ready = r[ocs_pkg::RDY_FAST];
      ocs_pkg::SRC_MEDIUM: src_ready = r[ocs_pkg::RDY_MED];
      ocs_pkg::SRC_SLOW: src_ready = r[ocs_pkg::RDY_SLOW];
      ocs_pkg::SRC_SECONDARY: src_ready = r[ocs_pkg::RDY_SEC];
      default: src_ready = 1'b0;
    endcase
  endfunction : src_ready

  assign src_rsv = ~is_valid_src(wbyte[ocs_pkg::SRC_LSB +: 3]);
  assign sel_rdy = src_ready(req_src_r, rdy_s2_r);

  // ==========================================================================
  // synchronisers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdy_s1_r <= ocs_pkg::RDY_RST; // RULE15
      rdy_s2_r <= ocs_pkg::RDY_RST; // RULE15
      fail_s1_r <= 1'b0;
      fail_s2_r <= 1'b0;
      fail_q_r <= 1'b0;
    end
    else
    begin
      rdy_s1_r <= osc_ready_i;
      rdy_s2_r <= rdy_s1_r; // RULE14
      fail_s1_r <= clock_fail_i;
      fail_s2_r <= fail_s1_r;
      fail_q_r <= fail_s2_r;
    end
  end

  // ==========================================================================
  // strap capture: taken on the first edge after release, never by reset
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      loaded_r <= 1'b0;
      allow_r <= 1'b0;
    end
    else if (!loaded_r)
    begin
      loaded_r <= 1'b1;
      allow_r <= switch_allow_config_i;
    end
  end

  // ==========================================================================
  // request fields
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      req_src_r <= ocs_pkg::SRC_RST;
      req_div_r <= ocs_pkg::DIV_RST;
    end
    else if (!loaded_r)
    begin
      req_src_r <= reset_source_config_i;
      req_div_r <= ocs_pkg::DIV_RST;
    end
    else if (fail_rise)
    begin
      req_src_r <= ocs_pkg::SRC_FAST; // RULE16
    end
    else if (wr_commit && idx == ocs_pkg::IDX_CLOCK_REQUEST && allow_r && !src_rsv) // RULE3 RULE4
    begin
      req_src_r <= wbyte[ocs_pkg::SRC_LSB +: 3]; // RULE1
      req_div_r <= wbyte[ocs_pkg::DIV_LSB +: 4]; // RULE2
    end
  end

  // ==========================================================================
  // switch sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= ocs_pkg::SW_IDLE;
      cur_src_r <= ocs_pkg::SRC_RST;
      cur_div_r <= ocs_pkg::DIV_RST;
      nsr_r <= 1'b0;
    end
    else if (!loaded_r)
    begin
      cur_src_r <= reset_source_config_i;
      cur_div_r <= ocs_pkg::DIV_RST;
    end
    else if (fail_rise)
    begin
      // fail-over bypasses the ready handshake: the fast source is the safe one
      cur_src_r <= ocs_pkg::SRC_FAST; // RULE16
      nsr_r <= 1'b0;
      st_r <= ocs_pkg::SW_IDLE;
    end
    else
    begin
      case (st_r)
        ocs_pkg::SW_IDLE:
        begin
          nsr_r <= 1'b0;
          if (!done_w)
          begin
            st_r <= ocs_pkg::SW_WAIT;
          end
        end
        ocs_pkg::SW_WAIT:
        begin
          if (done_w)
          begin
            st_r <= ocs_pkg::SW_IDLE;
          end
          else if (sel_rdy)
          begin
            nsr_r <= 1'b1; // RULE10 RULE11
            st_r <= hold_r ? ocs_pkg::SW_HOLD : ocs_pkg::SW_SWITCH; // RULE6 RULE7
          end
        end
        ocs_pkg::SW_HOLD:
        begin
          nsr_r <= sel_rdy & ~done_w; // RULE10
          if (done_w)
          begin
            st_r <= ocs_pkg::SW_IDLE;
          end
          else if (!sel_rdy)
          begin
            st_r <= ocs_pkg::SW_WAIT;
          end
          else if (!hold_r)
          begin
            st_r <= ocs_pkg::SW_SWITCH; // RULE18
          end
        end
        default:
        begin
          cur_src_r <= req_src_r; // RULE7 RULE11 RULE18
          cur_div_r <= req_div_r;
          nsr_r <= 1'b0; // RULE11
          st_r <= ocs_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // control, trim and frequency registers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_r <= 1'b0;
      pwr_r <= 1'b0;
    end
    else if (wr_commit && idx == ocs_pkg::IDX_SWITCH_CONTROL)
    begin
      hold_r <= wbyte[ocs_pkg::CTL_HOLD_BIT];
      pwr_r <= wbyte[ocs_pkg::CTL_PWR_BIT]; // RULE8
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      trim_r <= ocs_pkg::TRIM_RST; // RULE12
    end
    else if (auto_trim_en_i)
    begin
      trim_r <= auto_trim_value_i; // RULE17
    end
    else if (wr_commit && idx == ocs_pkg::IDX_FAST_OSC_TRIM)
    begin
      trim_r <= wbyte[5:0]; // RULE12
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frq_r <= ocs_pkg::FRQ_RST;
    end
    else if (wr_commit && idx == ocs_pkg::IDX_FAST_OSC_FREQUENCY &&
             wbyte[3:0] <= ocs_pkg::FRQ_MAX)
    begin
      // reserved codes are dropped so the oscillator never sees them
      frq_r <= wbyte[3:0]; // RULE13
    end
  end

  // ==========================================================================
  // interrupts: sticky, write one to clear, a new event beats the clear
  assign irq_set[ocs_pkg::IRQ_SWITCH_BIT] = (st_r == ocs_pkg::SW_SWITCH) && loaded_r && !fail_rise;
  assign irq_set[ocs_pkg::IRQ_FAIL_BIT] = fail_rise && loaded_r;
  assign irq_set[ocs_pkg::IRQ_HELD_BIT] = (st_r == ocs_pkg::SW_WAIT) && sel_rdy && hold_r &&
                                          !done_w && loaded_r && !fail_rise;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_sts_r <= ocs_pkg::IRQ_RST;
      irq_msk_r <= ocs_pkg::IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_commit && idx == ocs_pkg::IDX_IRQ_STATUS)
      begin
        irq_sts_r <= (irq_sts_r & ~wbyte[2:0]) | irq_set;
      end
      else
      begin
        irq_sts_r <= irq_sts_r | irq_set;
      end
      if (wr_commit && idx == ocs_pkg::IDX_IRQ_MASK)
      begin
        irq_msk_r <= wbyte[2:0];
      end
      irq_r <= |(irq_sts_r & irq_msk_r);
    end
  end

  // ==========================================================================
  // bus slave: waitrequest drops one cycle after the request, read data ready
  logic [7:0] rmux;
  always_comb
  begin
    rmux = 8'h00;
    if (idx == ocs_pkg::IDX_CLOCK_REQUEST)
      rmux = {1'b0, req_src_r, req_div_r};
    else if (idx == ocs_pkg::IDX_CLOCK_CURRENT)
      rmux = {1'b0, cur_src_r, cur_div_r}; // RULE5
    else if (idx == ocs_pkg::IDX_SWITCH_CONTROL)
      rmux = {hold_r, pwr_r, 1'b0, done_w, nsr_r, 3'h0}; // RULE9 RULE10
    else if (idx == ocs_pkg::IDX_FAST_OSC_TRIM)
      rmux = {2'h0, trim_r};
    else if (idx == ocs_pkg::IDX_FAST_OSC_FREQUENCY)
      rmux = {4'h0, frq_r};
    else if (idx == ocs_pkg::IDX_READY_FLAGS)
      rmux = {rdy_s2_r, 3'h0}; // RULE14
    else if (idx == ocs_pkg::IDX_IRQ_STATUS)
      rmux = {5'h00, irq_sts_r};
    else if (idx == ocs_pkg::IDX_IRQ_MASK)
      rmux = {5'h00, irq_msk_r};
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wait_r <= 1'b1;
      rdata_r <= ocs_pkg::RDATA_RST;
    end
    else if (req_any && wait_r)
    begin
      wait_r <= 1'b0;
      rdata_r <= {24'h00_0000, rmux};
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign current_source_o = cur_src_r;
  assign current_divider_o = cur_div_r;
  assign trim_value_o = trim_r;
  assign fast_freq_select_o = frq_r;
  assign secondary_power_select_o = pwr_r; // RULE8
  assign irq_o = irq_r;

  // ==========================================================================
  // checks
  property p_rsv_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
    wr_commit && idx == ocs_pkg::IDX_CLOCK_REQUEST && src_rsv && loaded_r && !fail_rise
    |=> $stable(req_src_r) && $stable(req_div_r);
  endproperty
  a_rsv_write: assert property (p_rsv_write) else $error("reserved source write changed request"); // RULE3

  property p_locked;
    @(posedge mclk_i) disable iff (sys_rst_i)
    loaded_r && !allow_r && !fail_rise |=> $stable(req_src_r) && $stable(req_div_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked request fields changed"); // RULE4

  property p_done;
    @(posedge mclk_i) disable iff (sys_rst_i)
    $changed(req_src_r) && req_src_r != cur_src_r |-> !done_w ##1 (st_r != ocs_pkg::SW_IDLE);
  endproperty
  a_done: assert property (p_done) else $error("done flag or pending state wrong"); // RULE9

  property p_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    st_r == ocs_pkg::SW_HOLD && hold_r && !fail_rise |=> $stable(cur_src_r) && $stable(cur_div_r);
  endproperty
  a_hold: assert property (p_hold) else $error("held switch completed"); // RULE6

  property p_nohold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    st_r == ocs_pkg::SW_WAIT && sel_rdy && !hold_r && !done_w && !fail_rise && loaded_r
    |=> nsr_r ##1 !nsr_r;
  endproperty
  a_nohold: assert property (p_nohold) else $error("unheld switch not done in two cycles"); // RULE7

  property p_nsr;
    @(posedge mclk_i) disable iff (sys_rst_i)
    nsr_r |-> !done_w && st_r != ocs_pkg::SW_IDLE;
  endproperty
  a_nsr: assert property (p_nsr) else $error("new ready flag without pending switch"); // RULE10

  property p_release;
    @(posedge mclk_i) disable iff (sys_rst_i)
    st_r == ocs_pkg::SW_HOLD && !hold_r && sel_rdy && !done_w && !fail_rise ##1 !fail_rise
    |=> cur_src_r == $past(req_src_r) && cur_div_r == $past(req_div_r);
  endproperty
  a_release: assert property (p_release) else $error("hold release did not switch"); // RULE18

  property p_fail;
    @(posedge mclk_i) disable iff (sys_rst_i)
    fail_rise && loaded_r |=> req_src_r == ocs_pkg::SRC_FAST && cur_src_r == ocs_pkg::SRC_FAST
    && irq_sts_r[ocs_pkg::IRQ_FAIL_BIT];
  endproperty
  a_fail: assert property (p_fail) else $error("clock fail not handled"); // RULE16

  property p_auto_trim;
    @(posedge mclk_i) disable iff (sys_rst_i)
    auto_trim_en_i |=> trim_r == $past(auto_trim_value_i);
  endproperty
  a_auto_trim: assert property (p_auto_trim) else $error("auto trim not followed"); // RULE17

endmodule : ocs_top

// [tb/tb_ocs_top.sv]
/*
  self-checking bench for ocs_top: register access, clock switching with and
  without hold, trim, frequency, ready flags, interrupt and clock fail.
  assumes the one-cycle avalon answer and 2ff synchronised status inputs.
*/
`timescale 1ns/1ps
module tb_ocs_top;
  // ==========================================================================
  // signals
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] avs_address_i = 12'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic switch_allow_config_i = 1'b1;
  logic [2:0] reset_source_config_i = 3'h6;
  logic [4:0] osc_ready_i = 5'h00;
  logic clock_fail_i = 1'b0;
  logic auto_trim_en_i = 1'b0;
  logic [5:0] auto_trim_value_i = 6'h00;
  logic [2:0] current_source_o;
  logic [3:0] current_divider_o;
  logic [5:0] trim_value_o;
  logic [3:0] fast_freq_select_o;
  logic secondary_power_select_o;
  logic irq_o;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] rd_v;

  ocs_top dut_u (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .switch_allow_config_i(switch_allow_config_i),
    .reset_source_config_i(reset_source_config_i), .osc_ready_i(osc_ready_i),
    .clock_fail_i(clock_fail_i), .auto_trim_en_i(auto_trim_en_i),
    .auto_trim_value_i(auto_trim_value_i), .current_source_o(current_source_o),
    .current_divider_o(current_divider_o), .trim_value_o(trim_value_o),
    .fast_freq_select_o(fast_freq_select_o),
    .secondary_power_select_o(secondary_power_select_o), .irq_o(irq_o)
  );

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // helpers
  task summarize;
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do
    begin
      @(posedge mclk_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 32);
    rd_v = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
    begin
      n_fail++;
      summarize();
    end
  endtask : bus

  task wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task rc(input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd_v, exp);
  endtask : rc

  // the switch must land within a few cycles of the synced ready
  task wait_cur(input logic [7:0] exp);
    int i;
    i = 0;
    while ({1'b0, current_source_o, current_divider_o} !== exp && i < 8)
    begin
      @(posedge mclk_i);
      i++;
    end
    chk({1'b0, current_source_o, current_divider_o}, exp);
    // a switch that never lands ends the run here, already counted above
    if ({1'b0, current_source_o, current_divider_o} !== exp)
    begin
      summarize();
    end
  endtask : wait_cur

  task rst;
    sys_rst_i <= 1'b1;
    tick(16);
    sys_rst_i <= 1'b0;
    tick(2);
  endtask : rst

  // ==========================================================================
  // scenarios
  task t_reset;
    rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h60);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h60);
    rc(ocs_pkg::IDX_READY_FLAGS, 8'h00);
    rc(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h00);
    rc(ocs_pkg::IDX_FAST_OSC_FREQUENCY, 8'h00);
    wr(10'h0b3, 8'hff);
    rc(10'h0b3, 8'h00);
  endtask : t_reset

  task t_request;
    wr(ocs_pkg::IDX_CLOCK_REQUEST, 8'h7f);
    rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h7f);
    for (int s = 0; s < 3; s++)
    begin
      wr(ocs_pkg::IDX_CLOCK_REQUEST, {1'b0, s[2:0], 4'h5});
      rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h7f);
    end
    wr(ocs_pkg::IDX_CLOCK_CURRENT, 8'h44);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h60);
    rc(ocs_pkg::IDX_SWITCH_CONTROL, 8'h00);
  endtask : t_request

  task t_switch;
    wr(ocs_pkg::IDX_CLOCK_REQUEST, 8'h53);
    tick(4);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h60);
    osc_ready_i <= 5'b00010;
    wait_cur(8'h53);
    rc(ocs_pkg::IDX_SWITCH_CONTROL, 8'h10);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h53);
    rc(ocs_pkg::IDX_IRQ_STATUS, 8'h01);
  endtask : t_switch

  task t_hold;
    wr(ocs_pkg::IDX_SWITCH_CONTROL, 8'h80);
    osc_ready_i <= 5'b11111;
    wr(ocs_pkg::IDX_CLOCK_REQUEST, 8'h32);
    tick(8);
    rc(ocs_pkg::IDX_SWITCH_CONTROL, 8'h88);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h53);
    rc(ocs_pkg::IDX_IRQ_STATUS, 8'h05);
    wr(ocs_pkg::IDX_SWITCH_CONTROL, 8'h00);
    wait_cur(8'h32);
    rc(ocs_pkg::IDX_SWITCH_CONTROL, 8'h10);
  endtask : t_hold

  task t_irq;
    wr(ocs_pkg::IDX_IRQ_MASK, 8'h07);
    tick(2);
    chk({7'h00, irq_o}, 8'h01);
    wr(ocs_pkg::IDX_IRQ_MASK, 8'h02);
    tick(2);
    chk({7'h00, irq_o}, 8'h00);
    wr(ocs_pkg::IDX_IRQ_STATUS, 8'h01);
    rc(ocs_pkg::IDX_IRQ_STATUS, 8'h04);
    wr(ocs_pkg::IDX_IRQ_STATUS, 8'h04);
    rc(ocs_pkg::IDX_IRQ_STATUS, 8'h00);
    wr(ocs_pkg::IDX_IRQ_MASK, 8'h07);
    tick(2);
    chk({7'h00, irq_o}, 8'h00);
  endtask : t_irq

  task t_power;
    wr(ocs_pkg::IDX_SWITCH_CONTROL, 8'h40);
    tick(1);
    chk({7'h00, secondary_power_select_o}, 8'h01);
    rc(ocs_pkg::IDX_SWITCH_CONTROL, 8'h50);
    wr(ocs_pkg::IDX_SWITCH_CONTROL, 8'h00);
    tick(1);
    chk({7'h00, secondary_power_select_o}, 8'h00);
  endtask : t_power

  task t_trim;
    wr(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h1f);
    rc(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h1f);
    wr(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h20);
    rc(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h20);
    // low byte not enabled: the write is answered but must not land
    avs_byteenable_i <= 4'he;
    wr(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h11);
    avs_byteenable_i <= 4'hf;
    rc(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h20);
    chk({2'b00, trim_value_o}, 8'h20);
    auto_trim_en_i <= 1'b1;
    auto_trim_value_i <= 6'h15;
    tick(2);
    wr(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h05);
    rc(ocs_pkg::IDX_FAST_OSC_TRIM, 8'h15);
    chk({2'b00, trim_value_o}, 8'h15);
    auto_trim_en_i <= 1'b0;
  endtask : t_trim

  task t_freq;
    logic [3:0] e;
    e = 4'h0;
    for (int c = 0; c < 16; c++)
    begin
      wr(ocs_pkg::IDX_FAST_OSC_FREQUENCY, c[7:0]);
      if (c <= 8)
        e = c[3:0];
      rc(ocs_pkg::IDX_FAST_OSC_FREQUENCY, {4'h0, e});
      chk({4'h0, fast_freq_select_o}, {4'h0, e});
    end
  endtask : t_freq

  task t_flags;
    osc_ready_i <= 5'b10101;
    tick(4);
    rc(ocs_pkg::IDX_READY_FLAGS, 8'ha8);
    osc_ready_i <= 5'b01010;
    tick(4);
    rc(ocs_pkg::IDX_READY_FLAGS, 8'h50);
  endtask : t_flags

  // locked straps, then a clock fail that must override the lock
  task t_lock_fail;
    switch_allow_config_i <= 1'b0;
    reset_source_config_i <= 3'h3;
    rst();
    rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h30);
    wr(ocs_pkg::IDX_CLOCK_REQUEST, 8'h53);
    rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h30);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h30);
    clock_fail_i <= 1'b1;
    tick(5);
    rc(ocs_pkg::IDX_CLOCK_REQUEST, 8'h60);
    rc(ocs_pkg::IDX_CLOCK_CURRENT, 8'h60);
    rc(ocs_pkg::IDX_IRQ_STATUS, 8'h02);
    clock_fail_i <= 1'b0;
  endtask : t_lock_fail

  // ==========================================================================
  // main sequence
  initial
  begin
    rst();
    t_reset();
    t_request();
    t_switch();
    t_hold();
    t_irq();
    t_power();
    t_trim();
    t_freq();
    t_flags();
    t_lock_fail();
    summarize();
  end
endmodule : tb_ocs_top
